// ### bench/mss_asserts.sv
`timescale 1ns/1ps
`include "mss_consts.vh"
module mss_asserts #(
  parameter MS_CYCLES = 4
) (
  input wire        clk,
  input wire        rstn,
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata_q,
  input wire [15:0] laser_setpoint_q,
  input wire        sweep_active_q,
  input wire        ramp_suspend_q
);
  reg [15:0] prev_q;
  reg [31:0] hold_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles the sweep output has held still
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 16'h0;
      hold_q <= 32'h0;
    end else begin
      prev_q <= laser_setpoint_q;
      hold_q <= (sweep_active_q && laser_setpoint_q == prev_q) ?
                hold_q + 32'h1 : 32'h0;
    end
  end
  AST_RD_IDLE: assert property (!$past(rd) |-> rdata_q == 32'h0)
    else $error("read data outside its cycle");
  AST_SUSPEND: assert property (ramp_suspend_q == sweep_active_q)
    else $error("ramp suspend differs from sweep state");
  AST_START: assert property (wr && addr == `MSS_REG_SW_EN &&
    wdata == 32'h1 |=> sweep_active_q) else $error("sweep did not start");
  AST_STOP: assert property (wr && addr == `MSS_REG_SW_EN &&
    wdata == 32'h0 |=> !sweep_active_q) else $error("sweep did not stop");
  AST_DWELL: assert property (sweep_active_q &&
    $past(sweep_active_q) && laser_setpoint_q != $past(laser_setpoint_q)
    |-> hold_q >= 10 * MS_CYCLES - 2) else $error("step inside a dwell");
  AST_END_HOLD: assert property ($fell(sweep_active_q) &&
    !$past(wr) |-> $stable(laser_setpoint_q))
    else $error("setpoint moved at sweep end");
  AST_COUNT_W: assert property (rd && addr == `MSS_REG_SW_COUNT
    |=> rdata_q[31:7] == 25'h0) else $error("count too wide");
  AST_UNMAPPED: assert property (rd && addr == 8'h80
    |=> rdata_q == 32'h0) else $error("unmapped read not zero");
  AST_RO_KIND: assert property (rd && addr == `MSS_REG_READOUT
    |=> rdata_q[31:30] != 2'h0) else $error("readout kind empty");
  AST_RO_EOL: assert property (rd && addr == `MSS_REG_READOUT
    ##1 rdata_q[31:30] == 2'h1 |-> rdata_q[29] == (rdata_q[28:27] == 2'h3))
    else $error("line end mark misplaced");
endmodule // mss_asserts

bind mss_top mss_asserts #(.MS_CYCLES(MS_CYCLES)) u_mss_asserts (
  .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .laser_setpoint_q(laser_setpoint_q),
  .sweep_active_q(sweep_active_q), .ramp_suspend_q(ramp_suspend_q));

// ### bench/mss_meas_model.sv
`timescale 1ns/1ps
module mss_meas_model (
  input  wire [15:0] setpoint,
  output wire [15:0] cur,
  output wire [15:0] fwd,
  output wire [15:0] monv,
  output wire [15:0] moni
);
  // Distinct offsets on the stored fields let each field of a set be traced; moni shares the fwd offset
  assign cur  = setpoint + 16'h0003;
  assign fwd  = setpoint + 16'h0100;
  assign monv = setpoint + 16'h0200;
  assign moni = setpoint + 16'h0100;
endmodule // mss_meas_model

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "mss_consts.vh"
module testbench;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [7:0]  addr = 8'h0;
  reg  [31:0] wdata = 32'h0;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  wire [31:0] rdata_q;
  wire [31:0] tgt;
  wire [15:0] cur, fwd, monv, moni, sp;
  wire        act, sus;
  reg  [31:0] v;
  integer     n_mismatch = 0;
  integer     total_checks = 0;
  integer     k;
  always #10 clk = ~clk;
  mss_top #(.MS_CYCLES(4)) u_mss_top (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .meas_laser_current(cur), .meas_fwd_voltage(fwd),
    .meas_mon_voltage(monv), .meas_mon_current(moni),
    .laser_setpoint_q(sp), .sweep_active_q(act), .ramp_suspend_q(sus),
    .reg_target_q(tgt));
  mss_meas_model u_mss_meas_model (
    .setpoint(sp), .cur(cur), .fwd(fwd), .monv(monv), .moni(moni));
  task check(input string n, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected %s: expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata_q;
    end
  endtask
  task rdchk(input [7:0] a, input string n, input [31:0] e);
    begin
      rd_reg(a);
      check(n, v, e);
    end
  endtask
  // Target is a registered level, so let writes settle
  task tchk(input [31:0] e);
    begin
      repeat (3) @(posedge clk);
      #1 check("target", tgt, e);
    end
  endtask
  task t_limits;
    begin
      wr_reg(`MSS_REG_MON_I_LIM, 32'h1388);
      wr_reg(`MSS_REG_MON_I_LIM, 32'h1389);
      rdchk(`MSS_REG_MON_I_LIM, "i_lim", 32'h1388);
      wr_reg(`MSS_REG_MON_I_SP, 32'h1389);
      rdchk(`MSS_REG_MON_I_SP, "i_sp", 32'h0);
      wr_reg(`MSS_REG_MON_P_LIM, 32'h1);
      rdchk(`MSS_REG_MON_P_LIM, "p_lim0", 32'h0);
      wr_reg(`MSS_REG_RESP, 32'ha);
      wr_reg(`MSS_REG_MON_P_LIM, 32'h1f4);
      wr_reg(`MSS_REG_MON_P_LIM, 32'h1f5);
      rdchk(`MSS_REG_MON_P_LIM, "p_lim", 32'h1f4);
      wr_reg(`MSS_REG_MON_P_SP, 32'h1f5);
      rdchk(`MSS_REG_MON_P_SP, "p_sp", 32'h0);
      wr_reg(8'h80, 32'h5);
      rdchk(8'h80, "unmapped", 32'h0);
    end
  endtask
  task t_target;
    begin
      wr_reg(`MSS_REG_MODE, 32'h1);
      wr_reg(`MSS_REG_MON_I_SP, 32'h3e8);
      wr_reg(`MSS_REG_ZERO_OFS, 32'hc8);
      tchk(32'h3e8);
      rdchk(`MSS_REG_MON_I_MEAS, "meas_raw", 32'h100);
      wr_reg(`MSS_REG_ZERO_EN, 32'h1);
      tchk(32'h4b0);
      rdchk(`MSS_REG_MON_I_MEAS, "meas_ofs", 32'h38);
      wr_reg(`MSS_REG_MON_P_SP, 32'h32);
      wr_reg(`MSS_REG_MODE, 32'h2);
      tchk(32'h2bc);
      wr_reg(`MSS_REG_MODE, 32'h3);
      rdchk(`MSS_REG_MODE, "mode", 32'h2);
      // Power mode without responsivity falls back to monitor current
      wr_reg(`MSS_REG_RESP, 32'h0);
      wr_reg(`MSS_REG_MODE, 32'h2);
      rdchk(`MSS_REG_MODE, "mode_fallback", 32'h1);
      wr_reg(`MSS_REG_MODE, 32'h0);
      tchk(32'h0);
    end
  endtask
  task t_setup;
    begin
      rdchk(`MSS_REG_SW_POINTS, "pts_rst", 32'h1);
      rdchk(`MSS_REG_SW_DWELL, "dwell_rst", 32'ha);
      wr_reg(`MSS_REG_SW_POINTS, 32'h0);
      wr_reg(`MSS_REG_SW_POINTS, 32'h65);
      rdchk(`MSS_REG_SW_POINTS, "pts", 32'h1);
      wr_reg(`MSS_REG_SW_DWELL, 32'h9);
      wr_reg(`MSS_REG_SW_DWELL, 32'hea61);
      rdchk(`MSS_REG_SW_DWELL, "dwell", 32'ha);
      wr_reg(`MSS_REG_SW_START, 32'h5dd);
      rdchk(`MSS_REG_SW_START, "start", 32'h0);
      wr_reg(`MSS_REG_SW_END, 32'h5dc);
      rdchk(`MSS_REG_SW_END, "end", 32'h5dc);
    end
  endtask
  task t_sweep;
    reg [1:0]  f;
    reg [15:0] s;
    reg [15:0] o;
    begin
      wr_reg(`MSS_REG_SW_START, 32'h64);
      wr_reg(`MSS_REG_SW_END, 32'h28);
      wr_reg(`MSS_REG_SW_POINTS, 32'h3);
      rdchk(`MSS_REG_SW_START, "su_start", 32'h64);
      rdchk(`MSS_REG_SW_END, "su_end", 32'h28);
      rdchk(`MSS_REG_SW_POINTS, "su_pts", 32'h3);
      rdchk(`MSS_REG_SW_DWELL, "su_dwell", 32'ha);
      rdchk(`MSS_REG_MODE, "mode_laser_i", 32'h0);
      wr_reg(`MSS_REG_SW_EN, 32'h1);
      @(posedge clk);
      #1 check("active", {act, sus, sp}, {2'h3, 16'h64});
      rd_reg(`MSS_REG_READOUT);
      check("early", v[31:30], `MSS_KIND_NO_NEW);
      repeat (55) @(posedge clk);
      #1 check("step", sp, 16'h46);
      rdchk(`MSS_REG_SW_COUNT, "count1", 32'h1);
      for (k = 0; k < 200 && act !== 1'b0; k = k + 1)
        @(posedge clk);
      #1 check("stopped", {act, sus, sp}, {2'h0, 16'h28});
      rdchk(`MSS_REG_SW_COUNT, "count3", 32'h3);
      // Drain every set before the next command
      for (k = 0; k < 12; k = k + 1) begin
        f = k % 4;
        s = 16'h64 - 16'h1e * (k / 4);
        o = (f == 2'h1) ? 16'h3 : (f == 2'h2) ? 16'h100 :
            (f == 2'h3) ? 16'h200 : 16'h0;
        rd_reg(`MSS_REG_READOUT);
        check("set", v, {`MSS_KIND_VALUE, f == 2'h3, f, 11'h0, s + o});
      end
      rd_reg(`MSS_REG_READOUT);
      check("eod", v[31:30], `MSS_KIND_END);
      rd_reg(`MSS_REG_READOUT);
      check("eod2", v[31:30], `MSS_KIND_END);
      wr_reg(`MSS_REG_SW_EN, 32'h1);
      rdchk(`MSS_REG_SW_COUNT, "count0", 32'h0);
      rd_reg(`MSS_REG_READOUT);
      check("empty", v[31:30], `MSS_KIND_NO_NEW);
      wr_reg(`MSS_REG_SW_EN, 32'h0);
      rdchk(`MSS_REG_SW_EN, "off", 32'h0);
      rd_reg(`MSS_REG_READOUT);
      check("eod3", v[31:30], `MSS_KIND_END);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_limits;
    t_target;
    t_setup;
    t_sweep;
    test_done;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
endmodule // testbench

// ### rtl/mss_consts.vh
`ifndef MSS_CONSTS_VH
`define MSS_CONSTS_VH

// Register byte offsets
`define MSS_REG_MODE        8'h00
`define MSS_REG_ZERO_EN     8'h04
`define MSS_REG_ZERO_OFS    8'h08
`define MSS_REG_RESP        8'h0c
`define MSS_REG_MON_I_LIM   8'h10
`define MSS_REG_MON_P_LIM   8'h14
`define MSS_REG_MON_I_SP    8'h18
`define MSS_REG_MON_P_SP    8'h1c
`define MSS_REG_SW_START    8'h20
`define MSS_REG_SW_END      8'h24
`define MSS_REG_SW_POINTS   8'h28
`define MSS_REG_SW_DWELL    8'h2c
`define MSS_REG_SW_EN       8'h30
`define MSS_REG_SW_COUNT    8'h34
`define MSS_REG_TARGET      8'h38
`define MSS_REG_MON_I_MEAS  8'h3c
`define MSS_REG_READOUT     8'h40
`define MSS_REG_STATUS      8'h44

// Mode codes
`define MSS_MODE_LASER_I    2'h0
`define MSS_MODE_MON_I      2'h1
`define MSS_MODE_MON_P      2'h2

// Ranges
`define MSS_MON_FULL_UA     32'h00001388
`define MSS_PTS_MIN         7'h01
`define MSS_PTS_MAX         7'h64
`define MSS_DWELL_MIN       16'h000a
`define MSS_DWELL_MAX       16'hea60

// Timing
`define MSS_CLK_HZ          50000000
`define MSS_MS_PER_S        1000

// Readout word layout
`define MSS_RO_KIND_HI      31
`define MSS_RO_KIND_LO      30
`define MSS_RO_EOL_BIT      29
`define MSS_RO_FLD_HI       28
`define MSS_RO_FLD_LO       27
`define MSS_KIND_VALUE      2'h1
`define MSS_KIND_END        2'h2
`define MSS_KIND_NO_NEW     2'h3

// Reset values
`define MSS_RST_POINTS      7'h01
`define MSS_RST_DWELL       16'h000a

`endif

// ### rtl/mss_top.v
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "mss_consts.vh"

module mss_top #(
  parameter        MS_CYCLES  = `MSS_CLK_HZ / `MSS_MS_PER_S,
  parameter [15:0] CUR_RATING = 16'd1500,
  parameter        DEPTH      = 128
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata_q,
  input  wire [15:0] meas_laser_current,
  input  wire [15:0] meas_fwd_voltage,
  input  wire [15:0] meas_mon_voltage,
  input  wire [15:0] meas_mon_current,
  output reg  [15:0] laser_setpoint_q,
  output reg         sweep_active_q,
  output reg         ramp_suspend_q,
  output reg  [31:0] reg_target_q
);

  localparam ST_IDLE  = 2'b01;
  localparam ST_DWELL = 2'b10;

  reg        rst_s1_q;
  reg        rst_s2_q;
  wire       rst_n = rst_s2_q;

  reg [1:0]  mode_q;
  reg        zero_en_q;
  reg [15:0] zero_ofs_q;
  reg [15:0] resp_q;
  reg [15:0] mon_i_lim_q;
  reg [15:0] mon_p_lim_q;
  reg [15:0] mon_i_sp_q;
  reg [15:0] mon_p_sp_q;
  reg [15:0] sw_start_q;
  reg [15:0] sw_end_q;
  reg [6:0]  sw_pts_q;
  reg [15:0] sw_dwell_q;
  reg [1:0]  state_q;
  reg [6:0]  count_q;
  reg [15:0] step_q;
  reg        down_q;
  reg [31:0] pre_q;
  reg [15:0] ms_q;
  reg [6:0]  ro_set_q;
  reg [1:0]  ro_fld_q;
  reg [63:0] mem [0:DEPTH-1];

  // Offset counts only when enabled and nonzero
  function [15:0] eff_ofs;
    input        en;
    input [15:0] ofs;
    begin
      eff_ofs = (en && ofs != 16'h0000) ? ofs : 16'h0000;
    end
  endfunction

  // Power in mW times responsivity, checked against full scale
  function in_scale;
    input [15:0] p;
    input [15:0] r;
    begin
      in_scale = (r != 16'h0000) && ({16'h0000, p} * {16'h0000, r} <=
                                     {32'h00000000, `MSS_MON_FULL_UA});
    end
  endfunction

  wire [15:0] ofs_use = eff_ofs(zero_en_q, zero_ofs_q);
  wire [15:0] wd16    = wdata[15:0];
  wire        running = state_q == ST_DWELL;
  wire        wr_en   = wr && addr == `MSS_REG_SW_EN;
  wire        start   = wr_en && wdata == 32'h00000001;
  wire        stop    = wr_en && wdata == 32'h00000000;
  wire        ms_tick = pre_q == MS_CYCLES - 1;
  wire        dwell_end = ms_tick && ms_q == sw_dwell_q - 16'h0001;
  wire        last_pt = count_q + 7'h01 == sw_pts_q;
  wire [15:0] diff    = (sw_end_q >= sw_start_q) ? sw_end_q - sw_start_q
                                                 : sw_start_q - sw_end_q;
  wire [15:0] step_calc = (sw_pts_q > 7'h01) ?
                          diff / {9'h000, sw_pts_q - 7'h01} : 16'h0000;
  wire [15:0] mon_corr = (meas_mon_current > ofs_use) ?
                         meas_mon_current - ofs_use : 16'h0000;
  wire        ro_rd   = rd && addr == `MSS_REG_READOUT;
  wire [63:0] ro_word = mem[ro_set_q];
  reg  [15:0] ro_val;
  reg  [31:0] ro_data;
  reg  [31:0] rd_mux;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Configuration writes with range checks
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q      <= `MSS_MODE_LASER_I;
      zero_en_q   <= 1'b0;
      zero_ofs_q  <= 16'h0000;
      resp_q      <= 16'h0000;
      mon_i_lim_q <= 16'h0000;
      mon_p_lim_q <= 16'h0000;
      mon_i_sp_q  <= 16'h0000;
      mon_p_sp_q  <= 16'h0000;
      sw_start_q  <= 16'h0000;
      sw_end_q    <= 16'h0000;
      sw_pts_q    <= `MSS_RST_POINTS;
      sw_dwell_q  <= `MSS_RST_DWELL;
    end else if (wr) begin
      case (addr)
        `MSS_REG_MODE: begin
          if (wdata == 32'h00000002 && resp_q == 16'h0000)
            mode_q <= `MSS_MODE_MON_I;
          else if (wdata <= 32'h00000002)
            mode_q <= wdata[1:0];
        end
        `MSS_REG_ZERO_EN: begin
          if (wdata <= 32'h00000001)
            zero_en_q <= wdata[0];
        end
        `MSS_REG_ZERO_OFS: begin
          if (wdata <= `MSS_MON_FULL_UA)
            zero_ofs_q <= wd16;
        end
        `MSS_REG_RESP: begin
          if (wdata[31:16] == 16'h0000)
            resp_q <= wd16;
        end
        `MSS_REG_MON_I_LIM: begin
          if (wdata <= `MSS_MON_FULL_UA)
            mon_i_lim_q <= wd16;
        end
        `MSS_REG_MON_P_LIM: begin
          // Zero responsivity refuses the write
          if (wdata[31:16] == 16'h0000 && in_scale(wd16, resp_q))
            mon_p_lim_q <= wd16;
        end
        `MSS_REG_MON_I_SP: begin
          if (wdata <= `MSS_MON_FULL_UA)
            mon_i_sp_q <= wd16;
        end
        `MSS_REG_MON_P_SP: begin
          if (wdata[31:16] == 16'h0000 && in_scale(wd16, resp_q))
            mon_p_sp_q <= wd16;
        end
        `MSS_REG_SW_START: begin
          if (wdata <= {16'h0000, CUR_RATING})
            sw_start_q <= wd16;
        end
        `MSS_REG_SW_END: begin
          if (wdata <= {16'h0000, CUR_RATING})
            sw_end_q <= wd16;
        end
        `MSS_REG_SW_POINTS: begin
          if (wdata >= {25'h0000000, `MSS_PTS_MIN} &&
              wdata <= {25'h0000000, `MSS_PTS_MAX})
            sw_pts_q <= wdata[6:0];
        end
        `MSS_REG_SW_DWELL: begin
          if (wdata >= {16'h0000, `MSS_DWELL_MIN} &&
              wdata <= {16'h0000, `MSS_DWELL_MAX})
            sw_dwell_q <= wd16;
        end
        default: begin
        end
      endcase
    end
  end

  // Sweep sequencer
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q          <= ST_IDLE;
      count_q          <= 7'h00;
      step_q           <= 16'h0000;
      down_q           <= 1'b0;
      pre_q            <= 32'h00000000;
      ms_q             <= 16'h0000;
      laser_setpoint_q <= 16'h0000;
      sweep_active_q   <= 1'b0;
      ramp_suspend_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q          <= ST_DWELL;
            count_q          <= 7'h00;
            step_q           <= step_calc;
            down_q           <= sw_end_q < sw_start_q;
            pre_q            <= 32'h00000000;
            ms_q             <= 16'h0000;
            laser_setpoint_q <= sw_start_q;
            sweep_active_q   <= 1'b1;
            ramp_suspend_q   <= 1'b1;
          end
        end
        ST_DWELL: begin
          if (stop) begin
            state_q        <= ST_IDLE;
            sweep_active_q <= 1'b0;
            ramp_suspend_q <= 1'b0;
          end else if (start) begin
            count_q          <= 7'h00;
            step_q           <= step_calc;
            down_q           <= sw_end_q < sw_start_q;
            pre_q            <= 32'h00000000;
            ms_q             <= 16'h0000;
            laser_setpoint_q <= sw_start_q;
          end else begin
            pre_q <= ms_tick ? 32'h00000000 : pre_q + 32'h00000001;
            if (ms_tick)
              ms_q <= dwell_end ? 16'h0000 : ms_q + 16'h0001;
            if (dwell_end) begin
              count_q <= count_q + 7'h01;
              if (last_pt) begin
                state_q        <= ST_IDLE;
                sweep_active_q <= 1'b0;
                ramp_suspend_q <= 1'b0;
              end else if (down_q) begin
                laser_setpoint_q <= laser_setpoint_q - step_q;
              end else begin
                laser_setpoint_q <= laser_setpoint_q + step_q;
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Result store, no reset needed for the data array
  always @(posedge clk) begin
    if (running && !start && !stop && dwell_end)
      mem[count_q] <= {meas_mon_voltage, meas_fwd_voltage,
                       meas_laser_current, laser_setpoint_q};
  end

  // Readout pointer walks field by field
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ro_set_q <= 7'h00;
      ro_fld_q <= 2'h0;
    end else if (start) begin
      ro_set_q <= 7'h00;
      ro_fld_q <= 2'h0;
    end else if (ro_rd && ro_set_q < count_q) begin
      ro_fld_q <= ro_fld_q + 2'h1;
      if (ro_fld_q == 2'h3)
        ro_set_q <= ro_set_q + 7'h01;
    end
  end

  always @* begin
    ro_val  = ro_word[15:0];
    ro_data = 32'h00000000;
    case (ro_fld_q)
      2'h0:    ro_val = ro_word[15:0];
      2'h1:    ro_val = ro_word[31:16];
      2'h2:    ro_val = ro_word[47:32];
      default: ro_val = ro_word[63:48];
    endcase
    if (ro_set_q < count_q) begin
      ro_data[`MSS_RO_KIND_HI:`MSS_RO_KIND_LO] = `MSS_KIND_VALUE;
      ro_data[`MSS_RO_EOL_BIT] = ro_fld_q == 2'h3;
      ro_data[`MSS_RO_FLD_HI:`MSS_RO_FLD_LO] = ro_fld_q;
      ro_data[15:0] = ro_val;
    end else if (running) begin
      ro_data[`MSS_RO_KIND_HI:`MSS_RO_KIND_LO] = `MSS_KIND_NO_NEW;
    end else begin
      ro_data[`MSS_RO_KIND_HI:`MSS_RO_KIND_LO] = `MSS_KIND_END;
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (addr)
      `MSS_REG_MODE:       rd_mux = {30'h00000000, mode_q};
      `MSS_REG_ZERO_EN:    rd_mux = {31'h00000000, zero_en_q};
      `MSS_REG_ZERO_OFS:   rd_mux = {16'h0000, zero_ofs_q};
      `MSS_REG_RESP:       rd_mux = {16'h0000, resp_q};
      `MSS_REG_MON_I_LIM:  rd_mux = {16'h0000, mon_i_lim_q};
      `MSS_REG_MON_P_LIM:  rd_mux = {16'h0000, mon_p_lim_q};
      `MSS_REG_MON_I_SP:   rd_mux = {16'h0000, mon_i_sp_q};
      `MSS_REG_MON_P_SP:   rd_mux = {16'h0000, mon_p_sp_q};
      `MSS_REG_SW_START:   rd_mux = {16'h0000, sw_start_q};
      `MSS_REG_SW_END:     rd_mux = {16'h0000, sw_end_q};
      `MSS_REG_SW_POINTS:  rd_mux = {25'h0000000, sw_pts_q};
      `MSS_REG_SW_DWELL:   rd_mux = {16'h0000, sw_dwell_q};
      `MSS_REG_SW_EN:      rd_mux = {31'h00000000, running};
      `MSS_REG_SW_COUNT:   rd_mux = {25'h0000000, count_q};
      `MSS_REG_TARGET:     rd_mux = reg_target_q;
      `MSS_REG_MON_I_MEAS: rd_mux = {16'h0000, mon_corr};
      `MSS_REG_READOUT:    rd_mux = ro_data;
      `MSS_REG_STATUS:     rd_mux = {30'h00000000, ramp_suspend_q, running};
      default:             rd_mux = 32'h00000000;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata_q <= 32'h00000000;
    else if (rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= 32'h00000000;
  end

  // Regulation target in uA
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      reg_target_q <= 32'h00000000;
    else begin
      case (mode_q)
        `MSS_MODE_MON_I:
          reg_target_q <= {16'h0000, mon_i_sp_q} +
                          {16'h0000, ofs_use};
        `MSS_MODE_MON_P:
          reg_target_q <= {16'h0000, mon_p_sp_q} * {16'h0000, resp_q} +
                          {16'h0000, ofs_use};
        default:
          reg_target_q <= 32'h00000000;
      endcase
    end
  end

endmodule // mss_top
